// ==== pkg/pmc_cfg.svh ====
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// register offsets (byte registers, 8-bit address)
`define PMC_OFS_CTRL      8'h00
`define PMC_OFS_PORTPD    8'h01
`define PMC_OFS_EEE       8'h02
`define PMC_OFS_EDTO      8'h03
`define PMC_OFS_STAT      8'h04
`define PMC_OFS_STRAP     8'h05

// mode field position and codes
`define PMC_MODE_LSB      3
`define PMC_MODE_MSB      4
`define PMC_MODE_NORMAL   2'h0
`define PMC_MODE_EDET     2'h1
`define PMC_MODE_SPD      2'h2
`define PMC_MODE_RSVD     2'h3

// reset values
`define PMC_RST_PORTPD    3'h0
`define PMC_RST_EEE       2'h3
`define PMC_RST_EDTO      8'h64

// timing: clock rate, microsecond tick, wake qualification
`define PMC_CLK_MHZ       100
`define PMC_TICK_NS       1000
`define PMC_TICK_CYC      ((`PMC_TICK_NS * `PMC_CLK_MHZ) / 1000)
`define PMC_ED_WAKE_NS    100
`define PMC_ED_WAKE_CYC   ((`PMC_ED_WAKE_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_WAKE_MAX_US   30
`define PMC_REFRESH_GAP_US 20000
`define PMC_REFRESH_LEN_US 200
`define PMC_LPULSE_GAP_US 16000

`endif

// ==== pkg/pmc_pkg.sv ====
`include "pmc_cfg.svh"
`default_nettype none

package pmc_pkg;

  // global power mode
  typedef enum logic [1:0] {
    PMC_NORMAL = `PMC_MODE_NORMAL,
    PMC_EDET   = `PMC_MODE_EDET,
    PMC_SPD    = `PMC_MODE_SPD
  } pmc_mode_t;

  // energy-detect sub-state
  typedef enum logic {
    ED_NORM = 1'b0,
    ED_LOW  = 1'b1
  } pmc_ed_t;

  // transmit low-power idle state, gray along off-quiet-refresh
  typedef enum logic [1:0] {
    LPI_OFF     = 2'b00,
    LPI_QUIET   = 2'b01,
    LPI_REFRESH = 2'b11
  } pmc_lpi_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmc_bus_t;

  // power enables toward the rest of the chip
  typedef struct packed {
    logic       pll;
    logic       host;
    logic       smi;
    logic [2:0] mac;
    logic [1:0] phy;
    logic [1:0] edet;
  } pmc_pwr_t;

  // per phy port eee status
  typedef struct packed {
    logic tx_lpi;
    logic tx_refresh;
    logic rx_lpi;
    logic active;
  } pmc_eee_t;

endpackage
`default_nettype wire

// ==== core/pmc_lpi_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"

module pmc_lpi_port #(
  parameter int GAP_US = `PMC_REFRESH_GAP_US,
  parameter int LEN_US = `PMC_REFRESH_LEN_US
) (
  input  wire  logic              i_mclk,
  input  wire  logic              i_rst,
  input  wire  logic              i_tick,
  input  wire  logic              i_active,
  input  wire  logic              i_tx_req,
  input  wire  logic              i_rx_pcode,
  input  wire  logic              i_rx_other,
  output var   pmc_pkg::pmc_eee_t o_eee
);
  import pmc_pkg::*;

  localparam int CW = $clog2(GAP_US + 1);
  localparam logic [CW-1:0] GAP_LAST = CW'(GAP_US - 1);
  localparam logic [CW-1:0] LEN_LAST = CW'(LEN_US - 1);

  pmc_lpi_t      tx_state;   // transmit lpi state
  pmc_lpi_t      next_tx;    // its next value
  logic [CW-1:0] cnt;        // microsecond count inside quiet or refresh
  logic [CW-1:0] next_cnt;
  logic          rx_lpi;     // receive direction in lpi
  logic          next_rx;

  // transmit side: quiet periods broken by refresh bursts
  always_comb begin
    next_tx  = tx_state;
    next_cnt = cnt;
    case (tx_state)
      LPI_OFF: begin
        next_cnt = '0;
        if (i_active && i_tx_req) begin
          next_tx = LPI_QUIET;
        end
      end
      LPI_QUIET: begin
        if (!i_active || !i_tx_req) begin
          next_tx = LPI_OFF;
        end else if (i_tick && cnt == GAP_LAST) begin
          next_tx  = LPI_REFRESH;
          next_cnt = '0;
        end else if (i_tick) begin
          next_cnt = cnt + 1'b1;
        end
      end
      LPI_REFRESH: begin
        // wake takes priority over finishing the refresh burst
        if (!i_active || !i_tx_req) begin
          next_tx = LPI_OFF;
        end else if (i_tick && cnt == LEN_LAST) begin
          next_tx  = LPI_QUIET;
          next_cnt = '0;
        end else if (i_tick) begin
          next_cnt = cnt + 1'b1;
        end
      end
      default: begin
        next_tx  = LPI_OFF;
        next_cnt = '0;
      end
    endcase
  end

  // receive side: p code enters, anything else leaves; leaving wins
  assign next_rx = i_active && !i_rx_other && (rx_lpi || i_rx_pcode);

  // state flops
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_state <= LPI_OFF;
      cnt      <= '0;
      rx_lpi   <= 1'b0;
    end else begin
      tx_state <= next_tx;
      cnt      <= next_cnt;
      rx_lpi   <= next_rx;
    end
  end

  assign o_eee = '{tx_lpi: tx_state != LPI_OFF, tx_refresh: tx_state == LPI_REFRESH,
                   rx_lpi: rx_lpi, active: i_active};

  tx_wake_fast_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (tx_state != LPI_OFF && !i_tx_req) |=> tx_state == LPI_OFF)
    else $error("tx lpi not left one cycle after request drop");

  rx_gated_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_active |=> !rx_lpi)
    else $error("rx lpi while eee inactive");

  refresh_entry_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (tx_state == LPI_REFRESH && $past(tx_state) != LPI_REFRESH) |-> $past(tx_state) == LPI_QUIET)
    else $error("refresh entered from wrong state");

endmodule
`default_nettype wire

// ==== core/pmc_top.sv ====
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"


module pmc_top #(
  parameter int REFRESH_GAP_US = `PMC_REFRESH_GAP_US,
  parameter int REFRESH_LEN_US = `PMC_REFRESH_LEN_US,
  parameter int LPULSE_GAP_US  = `PMC_LPULSE_GAP_US
) (
  input  wire  logic                    i_mclk,
  input  wire  logic                    i_rst,
  input  wire  pmc_pkg::pmc_bus_t       i_bus,
  output var   logic [7:0]              o_rdata,
  input  wire  logic [7:0]              i_strap,
  output var   logic [7:0]              o_strap,
  input  wire  logic [1:0]              i_energy,
  input  wire  logic [1:0]              i_an_eee_ok,
  input  wire  logic [1:0]              i_tx_lpi_req,
  input  wire  logic [1:0]              i_rx_pcode,
  input  wire  logic [1:0]              i_rx_other,
  output var   pmc_pkg::pmc_pwr_t       o_pwr,
  output var   logic                    o_link_pulse,
  output var   pmc_pkg::pmc_eee_t [1:0] o_eee
);
  import pmc_pkg::*;

  localparam logic [6:0] TICK_LAST = 7'(`PMC_TICK_CYC - 1);
  localparam logic [3:0] WAKE_CYC  = 4'(`PMC_ED_WAKE_CYC);
  localparam int         PW        = $clog2(LPULSE_GAP_US + 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(LPULSE_GAP_US - 1);

  // software state
  pmc_mode_t   mode;        // current global mode
  logic [2:0]  port_pd;     // per port power-down, bit0 = port 1
  logic [1:0]  eee_en;      // eee enable, phy ports only
  logic [7:0]  ed_timeout;  // energy absence limit in microseconds
  logic        strap_done;  // straps caught after reset release

  // timing and energy-detect state
  logic [6:0]  tick_cnt;    // divider toward the microsecond tick
  logic        tick;        // one-cycle microsecond enable
  pmc_ed_t     ed_state;    // energy-detect sub-state
  pmc_ed_t     next_ed;
  logic [7:0]  absent_cnt;  // microseconds without energy
  logic [7:0]  next_absent;
  logic [3:0]  energy_cnt;  // consecutive cycles with energy
  logic [PW-1:0] pulse_cnt; // microseconds since last link pulse
  pmc_pwr_t    next_pwr;
  pmc_eee_t [1:0] eee;

  // bus decode
  wire [1:0] wmode     = i_bus.wdata[`PMC_MODE_MSB:`PMC_MODE_LSB];
  wire       wr_ctrl   = i_bus.wr && i_bus.addr == `PMC_OFS_CTRL;
  wire       wr_portpd = i_bus.wr && i_bus.addr == `PMC_OFS_PORTPD;
  wire       wr_eee    = i_bus.wr && i_bus.addr == `PMC_OFS_EEE;
  wire       wr_edto   = i_bus.wr && i_bus.addr == `PMC_OFS_EDTO;
  // reserved code 11 is dropped so the mode stays one of three
  wire       mode_ok   = wmode != `PMC_MODE_RSVD;
  // any write naming another mode ends soft power-down
  wire       spd_exit  = wr_ctrl && mode == PMC_SPD && wmode != `PMC_MODE_SPD;
  wire       strap_take = !strap_done || spd_exit;

  // energy helpers
  wire       energy    = |i_energy;
  wire       ed_active = mode == PMC_EDET;
  wire       ed_low    = ed_state == ED_LOW;
  // low state counts only while the mode still asks for it; the machine lags a mode write by a cycle
  wire       ed_sleep  = ed_low && ed_active;
  wire       full_on   = mode == PMC_NORMAL || (ed_active && !ed_low);

  // status word: rx lpi, tx lpi, mode, low-power flag
  wire [7:0] stat_val = {1'b0, eee[1].rx_lpi, eee[0].rx_lpi, eee[1].tx_lpi, eee[0].tx_lpi,
                         mode, ed_low};

  // read mux, unmapped reads give zero
  wire [7:0] rd_val =
    (i_bus.addr == `PMC_OFS_CTRL)   ? {3'h0, mode, 3'h0} :
    (i_bus.addr == `PMC_OFS_PORTPD) ? {5'h0, port_pd} :
    (i_bus.addr == `PMC_OFS_EEE)    ? {6'h0, eee_en} :
    (i_bus.addr == `PMC_OFS_EDTO)   ? ed_timeout :
    (i_bus.addr == `PMC_OFS_STAT)   ? stat_val :
    (i_bus.addr == `PMC_OFS_STRAP)  ? o_strap : 8'h00;

  // register file; soft power-down exit overrides a same-cycle write
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode       <= PMC_NORMAL;
      port_pd    <= `PMC_RST_PORTPD;
      eee_en     <= `PMC_RST_EEE;
      ed_timeout <= `PMC_RST_EDTO;
    end else if (spd_exit) begin
      mode       <= PMC_NORMAL;
      port_pd    <= `PMC_RST_PORTPD;
      eee_en     <= `PMC_RST_EEE;
      ed_timeout <= `PMC_RST_EDTO;
    end else begin
      if (wr_ctrl && mode_ok) begin
        mode <= pmc_mode_t'(wmode);
      end
      if (wr_portpd) begin
        port_pd <= i_bus.wdata[2:0];
      end
      if (wr_eee) begin
        eee_en <= i_bus.wdata[1:0];
      end
      if (wr_edto) begin
        ed_timeout <= i_bus.wdata;
      end
    end
  end

  // strap capture one edge after reset release and on soft power-down exit
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      strap_done <= 1'b0;
      o_strap    <= 8'h00;
    end else begin
      strap_done <= 1'b1;
      if (strap_take) begin
        o_strap <= i_strap;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_bus.rd ? rd_val : 8'h00;
    end
  end

  // microsecond tick divider
  // one shared tick keeps every microsecond timer in step
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= 7'h00;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= (tick_cnt == TICK_LAST) ? 7'h00 : tick_cnt + 7'h01;
      tick     <= tick_cnt == TICK_LAST;
    end
  end

  // energy-detect machine: absence timer down, energy run up
  always_comb begin
    next_ed     = ed_state;
    next_absent = absent_cnt;
    case (ed_state)
      ED_NORM: begin
        if (!ed_active || energy) begin
          next_absent = 8'h00;
        // the tick that would pass 255 counts too, so a limit of 255 still expires
        end else if (absent_cnt > ed_timeout || (tick && absent_cnt == 8'hFF)) begin
          next_ed     = ED_LOW;
          next_absent = 8'h00;
        end else if (tick && absent_cnt != 8'hFF) begin
          next_absent = absent_cnt + 8'h01;
        end
      end
      ED_LOW: begin
        next_absent = 8'h00;
        // energy seen for more than the wake window brings power back
        if (!ed_active || (energy && energy_cnt == WAKE_CYC)) begin
          next_ed = ED_NORM;
        end
      end
      default: begin
        next_ed     = ED_NORM;
        next_absent = 8'h00;
      end
    endcase
  end

  // energy-detect flops
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ed_state   <= ED_NORM;
      absent_cnt <= 8'h00;
      energy_cnt <= 4'h0;
    end else begin
      ed_state   <= next_ed;
      absent_cnt <= next_absent;
      energy_cnt <= (energy && ed_low) ? ((energy_cnt == 4'hF) ? 4'hF : energy_cnt + 4'h1) : 4'h0;
    end
  end

  // sparse link pulses in low-power, one cycle every gap
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pulse_cnt    <= '0;
      o_link_pulse <= 1'b0;
    end else begin
      o_link_pulse <= ed_sleep && tick && pulse_cnt == PULSE_LAST;
      if (!ed_sleep || (tick && pulse_cnt == PULSE_LAST)) begin
        pulse_cnt <= '0;
      end else if (tick) begin
        pulse_cnt <= pulse_cnt + 1'b1;
      end
    end
  end

  // power enables from mode and per-port power-down, registered out
  assign next_pwr.pll  = full_on;
  assign next_pwr.host = full_on;
  assign next_pwr.smi  = 1'b1;
  assign next_pwr.mac  = {3{full_on}} & ~port_pd;
  assign next_pwr.phy  = {2{full_on}} & ~port_pd[1:0];
  assign next_pwr.edet = {2{ed_sleep}} & ~port_pd[1:0];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_pwr <= '0;
    end else begin
      o_pwr <= next_pwr;
    end
  end

  // eee on the two phy ports only; the mac port has no lpi logic
  for (genvar p = 0; p < 2; p++) begin : g_eee
    pmc_lpi_port #(
      .GAP_US (REFRESH_GAP_US),
      .LEN_US (REFRESH_LEN_US)
    ) u_lpi (
      .i_mclk     (i_mclk),
      .i_rst      (i_rst),
      .i_tick     (tick),
      .i_active   (eee_en[p] && i_an_eee_ok[p] && o_pwr.phy[p]),
      .i_tx_req   (i_tx_lpi_req[p]),
      .i_rx_pcode (i_rx_pcode[p]),
      .i_rx_other (i_rx_other[p]),
      .o_eee      (eee[p])
    );
  end

  assign o_eee = eee;

  normal_power_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    mode == PMC_NORMAL |=> (o_pwr.pll && o_pwr.host && o_pwr.mac == ~$past(port_pd)))
    else $error("normal mode lacks power");

  low_state_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ed_sleep |=> (!o_pwr.pll && !o_pwr.host && o_pwr.mac == 3'h0 && o_pwr.phy == 2'h0))
    else $error("low-power state left circuits on");

  spd_only_smi_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    mode == PMC_SPD |=> (!o_pwr.pll && o_pwr.mac == 3'h0 && o_pwr.edet == 2'h0 && o_pwr.smi))
    else $error("soft power-down left functions on");

  spd_defaults_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    spd_exit |=> (mode == PMC_NORMAL && eee_en == `PMC_RST_EEE && o_strap == $past(i_strap)))
    else $error("soft power-down exit missed defaults");

  rsvd_ignored_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_ctrl && wmode == `PMC_MODE_RSVD && mode != PMC_SPD) |=> mode == $past(mode))
    else $error("reserved mode code accepted");

  energy_wake_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ed_low && ed_active && energy)[*8] ##1 (energy && ed_active)[*3] |=> ed_state == ED_NORM)
    else $error("no wake after qualified energy");

  quiet_stays_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ed_low && ed_active && !energy) |=> ed_low)
    else $error("low-power left without energy");

  ed_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !ed_active |=> (ed_state == ED_NORM && absent_cnt == 8'h00))
    else $error("energy-detect machine ran outside its mode");

  eee_default_a: assert property (@(posedge i_mclk)
    $fell(i_rst) |-> eee_en == `PMC_RST_EEE)
    else $error("eee not enabled after reset");

  pulse_low_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_link_pulse |-> $past(ed_sleep))
    else $error("link pulse outside low-power state");

  rdata_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");

endmodule
`default_nettype wire

// ==== bench/pmc_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module pmc_host (
  input  wire logic              i_mclk,
  output var  pmc_pkg::pmc_bus_t o_bus
);
  import pmc_pkg::*;

  // bus idle from time zero
  initial o_bus = '0;

  // write strobe for one cycle; any mode code may be written
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    o_bus <= '0;
  endtask

  // read strobe for one cycle; data stands only in the cycle after
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    o_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    o_bus <= '0;
  endtask
endmodule

`default_nettype wire

// ==== bench/power_mode_controller_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller_test;
  import pmc_pkg::*;

  // table row: optional write, then read back
  typedef struct {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } pmc_row_t;

  logic           i_mclk;          // core clock
  logic           i_rst;           // async reset
  pmc_bus_t       i_bus;           // host request
  logic [7:0]     o_rdata;         // read data
  logic [7:0]     i_strap;         // strap levels
  logic [7:0]     o_strap;         // captured straps
  logic [1:0]     i_energy;        // cable energy
  logic [1:0]     i_an_eee_ok;     // partner eee support
  logic [1:0]     i_tx_lpi_req;    // mac lpi request
  logic [1:0]     i_rx_pcode;      // refresh code seen
  logic [1:0]     i_rx_other;      // other code seen
  pmc_pwr_t       o_pwr;           // power enables
  logic           o_link_pulse;    // link pulse
  pmc_eee_t [1:0] o_eee;           // eee status
  int             n_fail = 0;      // mismatches
  int             comparisons = 0; // checks made
  int             i;               // poll counter
  pmc_row_t       rows [8];        // register cases

  // short counts keep the run brief
  pmc_top #(.REFRESH_GAP_US(5), .REFRESH_LEN_US(2), .LPULSE_GAP_US(4)) u_pmc_top (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_bus        (i_bus),
    .o_rdata      (o_rdata),
    .i_strap      (i_strap),
    .o_strap      (o_strap),
    .i_energy     (i_energy),
    .i_an_eee_ok  (i_an_eee_ok),
    .i_tx_lpi_req (i_tx_lpi_req),
    .i_rx_pcode   (i_rx_pcode),
    .i_rx_other   (i_rx_other),
    .o_pwr        (o_pwr),
    .o_link_pulse (o_link_pulse),
    .o_eee        (o_eee)
  );

  pmc_host u_pmc_host (
    .i_mclk (i_mclk),
    .o_bus  (i_bus)
  );

  // 100 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // count a comparison, report a mismatch
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // read one register and compare the byte
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_pmc_host.rd(a);
    #1;
    chk($sformatf("reg %h", a), {2'h0, e}, {2'h0, o_rdata});
  endtask

  // let n edges pass, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // verdict, the single end of the run
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog, well past the few thousand cycles expected
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    close_out();
  end

  initial begin
    i_rst = 1'b1;
    i_strap = 8'hA5;
    i_energy = 2'b00;
    i_an_eee_ok = 2'b01; // autoneg kept on, only port 1 partner capable
    i_tx_lpi_req = 2'b00;
    i_rx_pcode = 2'b00;
    i_rx_other = 2'b00;
    rows = '{'{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h01, 8'h00, 8'h00},
             '{1'b0, 8'h02, 8'h00, 8'h03}, '{1'b0, 8'h03, 8'h00, 8'h64},
             '{1'b0, 8'h05, 8'h00, 8'hA5}, '{1'b0, 8'h07, 8'h00, 8'h00},
             '{1'b1, 8'h04, 8'hFF, 8'h00}, '{1'b1, 8'h02, 8'hFF, 8'h03}};
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    cyc(2);
    chk("pwr normal", 10'h3FC, o_pwr);
    // reset values, read-only and unmapped places
    foreach (rows[k]) begin
      if (rows[k].wr) u_pmc_host.wr(rows[k].addr, rows[k].wdata);
      rdchk(rows[k].addr, rows[k].exp);
    end
    // power down port 2 alone
    u_pmc_host.wr(8'h01, 8'h02);
    cyc(2);
    chk("port2 off", 10'h015, 10'({o_pwr.mac, o_pwr.phy}));
    u_pmc_host.wr(8'h01, 8'h00);
    // energy detect with a two microsecond timeout
    u_pmc_host.wr(8'h03, 8'h02);
    u_pmc_host.wr(8'h00, 8'h08);
    rdchk(8'h04, 8'h02);
    for (i = 0; i < 1000 && o_pwr.pll !== 1'b0; i++) cyc(1);
    chk("absent wait", 10'h001, 10'(i > 150));
    chk("pwr low", 10'h083, o_pwr);
    rdchk(8'h04, 8'h03);
    for (i = 0; i < 600 && o_link_pulse !== 1'b1; i++) cyc(1);
    chk("link pulse", 10'h001, 10'(o_link_pulse));
    // a short burst of energy must not wake the device
    @(posedge i_mclk);
    i_energy <= 2'b11;
    repeat (5) @(posedge i_mclk);
    i_energy <= 2'b00;
    cyc(20);
    chk("short energy", 10'h000, 10'(o_pwr.pll));
    @(posedge i_mclk);
    i_energy <= 2'b11;
    cyc(16);
    chk("wake", 10'h001, 10'(o_pwr.pll));
    // reserved code ignored, then back to normal
    u_pmc_host.wr(8'h00, 8'h18);
    rdchk(8'h00, 8'h08);
    u_pmc_host.wr(8'h00, 8'h00);
    rdchk(8'h04, 8'h00);
    @(posedge i_mclk);
    i_energy <= 2'b00;
    cyc(400);
    chk("normal holds", 10'h3FC, o_pwr);
    // soft power-down with dirty registers, straps changed meanwhile
    u_pmc_host.wr(8'h01, 8'h01);
    u_pmc_host.wr(8'h02, 8'h00);
    u_pmc_host.wr(8'h00, 8'h10);
    cyc(2);
    chk("pwr spd", 10'h080, o_pwr);
    rdchk(8'h00, 8'h10);
    @(posedge i_mclk);
    i_strap <= 8'h3C;
    u_pmc_host.wr(8'h00, 8'h00);
    cyc(2);
    chk("strap", 10'h03C, 10'(o_strap));
    chk("pwr exit", 10'h3FC, o_pwr);
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h03);
    // eee: port 1 negotiated, port 2 not
    chk("eee active", 10'h001, 10'({o_eee[1].active, o_eee[0].active}));
    @(posedge i_mclk);
    i_tx_lpi_req <= 2'b11;
    cyc(1);
    chk("tx lpi", 10'h001, 10'({o_eee[1].tx_lpi, o_eee[0].tx_lpi}));
    for (i = 0; i < 800 && o_eee[0].tx_refresh !== 1'b1; i++) cyc(1);
    chk("refresh", 10'h001, 10'(o_eee[0].tx_refresh));
    chk("refresh gap", 10'h001, 10'(i > 350));
    // receive side follows its own codes
    @(posedge i_mclk);
    i_rx_pcode <= 2'b01;
    @(posedge i_mclk);
    i_rx_pcode <= 2'b00;
    #1;
    chk("rx lpi on", 10'h001, 10'(o_eee[0].rx_lpi));
    @(posedge i_mclk);
    i_rx_other <= 2'b01;
    @(posedge i_mclk);
    i_rx_other <= 2'b00;
    #1;
    chk("rx lpi off", 10'h000, 10'(o_eee[0].rx_lpi));
    // traffic returns: leave lpi at once
    @(posedge i_mclk);
    i_tx_lpi_req <= 2'b00;
    cyc(1);
    chk("tx wake", 10'h000, 10'(o_eee[0].tx_lpi));
    u_pmc_host.wr(8'h02, 8'h02);
    cyc(1);
    chk("eee off", 10'h000, 10'(o_eee[0].active));
    // reset in mid-run: everything back to defaults, straps caught again
    @(posedge i_mclk);
    i_rst <= 1'b1;
    i_strap <= 8'h5A;
    cyc(2);
    chk("pwr in reset", 10'h000, o_pwr);
    @(posedge i_mclk);
    i_rst <= 1'b0;
    cyc(2);
    chk("pwr after reset", 10'h3FC, o_pwr);
    chk("strap at reset", 10'h05A, 10'(o_strap));
    rdchk(8'h02, 8'h03);
    close_out();
  end
endmodule

`default_nettype wire
